/* File: hw/fpc_host.sv */
`timescale 1ns/10ps
module fpc_host (
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    input  wire logic [7:0]                 addr_in,
    input  wire logic [31:0]                wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    output logic [31:0]                     rdata_out,
    output logic [fpc_pkg::ADDR_W-1:0]      fl_addr_out,
    input  wire logic [fpc_pkg::DATA_W-1:0] fl_dq_in,
    output logic [fpc_pkg::DATA_W-1:0]      fl_dq_out,
    output logic                            fl_dq_oe_n_out,
    output logic                            fl_ce_n_out,
    output logic                            fl_oe_n_out,
    output logic                            fl_we_n_out
);
    typedef enum logic [3:0] {
        S_WAIT    = 4'b0000,
        S_IDLE    = 4'b0001,
        S_CHECK   = 4'b0010,
        S_SEQ     = 4'b0011,
        S_POLL1   = 4'b0100,
        S_POLL2   = 4'b0101,
        S_READ    = 4'b0110,
        S_ID      = 4'b0111,
        S_RECOVER = 4'b1000
    } fpc_state_e;

    fpc_state_e                  state_reg;
    logic [2:0]                  op_reg;
    logic [fpc_pkg::ADDR_W-1:0]  addr_reg;
    logic [7:0]                  wdata_reg;
    logic [7:0]                  rdata_reg;
    logic [7:0]                  blocks_reg;
    logic [15:0]                 id_reg;
    logic [7:0]                  prev_reg;
    logic [2:0]                  step_reg;
    logic [2:0]                  blk_reg;
    logic                        idsel_reg;
    logic                        fail_reg;
    logic                        done_reg;
    logic                        refused_reg;
    logic                        err_seen_reg;
    logic                        cyc_start;
    logic                        cyc_write;
    logic [fpc_pkg::ADDR_W-1:0]  cyc_addr;
    logic [7:0]                  cyc_data;
    logic                        cyc_done;
    logic [7:0]                  cyc_rdata;
    logic                        tmr_load;
    logic [15:0]                 tmr_count;
    logic                        tmr_idle;
    logic                        busy;

    // toggle bit stopped between two reads means operation finished
    function automatic logic toggling(input logic [7:0] a, input logic [7:0] b);
        return a[fpc_pkg::TOGGLE_BIT] != b[fpc_pkg::TOGGLE_BIT];
    endfunction

    function automatic logic [fpc_pkg::ADDR_W-1:0] blk_base(input logic [2:0] b);
        return {b, 14'h0000};
    endfunction

    assign busy = (state_reg != S_IDLE);

    // bus cycle sequencing of unlock, command and data writes and of flash reads
    always_comb begin
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        cyc_addr  = 17'(fpc_pkg::UNLOCK_A1);
        cyc_data  = fpc_pkg::UNLOCK_D1;
        case (state_reg)
            S_SEQ: begin
                cyc_start = 1'b1;
                case (step_reg)
                    3'h0: begin
                        cyc_addr = 17'(fpc_pkg::UNLOCK_A1);
                        cyc_data = (op_reg == fpc_pkg::OP_RESET) ? fpc_pkg::CODE_RESET : fpc_pkg::UNLOCK_D1;
                    end
                    3'h1: begin
                        cyc_addr = 17'(fpc_pkg::UNLOCK_A2);
                        cyc_data = fpc_pkg::UNLOCK_D2;
                    end
                    3'h2: begin
                        cyc_addr = 17'(fpc_pkg::UNLOCK_A1);
                        case (op_reg)
                            fpc_pkg::OP_PROGRAM: cyc_data = fpc_pkg::CODE_PROGRAM;
                            fpc_pkg::OP_READ_ID: cyc_data = fpc_pkg::CODE_ID;
                            default:             cyc_data = fpc_pkg::CODE_ERASE;
                        endcase
                    end
                    3'h3: begin
                        if (op_reg == fpc_pkg::OP_PROGRAM) begin
                            cyc_addr = addr_reg;
                            cyc_data = wdata_reg;
                        end else begin
                            cyc_addr = 17'(fpc_pkg::UNLOCK_A1);
                            cyc_data = fpc_pkg::UNLOCK_D1;
                        end
                    end
                    3'h4: begin
                        cyc_addr = 17'(fpc_pkg::UNLOCK_A2);
                        cyc_data = fpc_pkg::UNLOCK_D2;
                    end
                    default: begin
                        // block erase repeats this step per chosen block
                        if (op_reg == fpc_pkg::OP_BLOCK_ERASE) begin
                            // hold off until the skip logic lands on a chosen block
                            cyc_start = blocks_reg[blk_reg];
                            cyc_addr  = blk_base(blk_reg);
                            cyc_data = fpc_pkg::CODE_BLOCK;
                        end else begin
                            cyc_addr = 17'(fpc_pkg::UNLOCK_A1);
                            cyc_data = fpc_pkg::CODE_CHIP;
                        end
                    end
                endcase
            end
            S_CHECK, S_POLL1, S_POLL2, S_READ, S_RECOVER: begin
                cyc_start = 1'b1;
                cyc_write = 1'b0;
                cyc_addr  = addr_reg;
            end
            S_ID: begin
                cyc_start = 1'b1;
                cyc_write = 1'b0;
                cyc_addr  = {15'h0000, 1'b0, idsel_reg};
            end
            default: begin
                cyc_start = 1'b0;
            end
        endcase
    end

    fpc_bus_cycle u_cycle (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (cyc_start),
        .write_in    (cyc_write),
        .addr_in     (cyc_addr),
        .wdata_in    (cyc_data),
        .dq_in       (fl_dq_in),
        .done_out    (cyc_done),
        .rdata_out   (cyc_rdata),
        .addr_out    (fl_addr_out),
        .dq_out      (fl_dq_out),
        .dq_oe_n_out (fl_dq_oe_n_out),
        .ce_n_out    (fl_ce_n_out),
        .oe_n_out    (fl_oe_n_out),
        .we_n_out    (fl_we_n_out)
    );

    assign tmr_load  = (state_reg == S_SEQ) && cyc_done && (op_reg == fpc_pkg::OP_RESET) && err_seen_reg;
    assign tmr_count = 16'(fpc_pkg::RESET_READY_CYC);

    fpc_timer u_timer (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .load_in     (tmr_load),
        .count_in    (tmr_count),
        .idle_out    (tmr_idle)
    );

    // last sequence step index for the current command
    function automatic logic [2:0] last_step(input logic [2:0] op);
        case (op)
            fpc_pkg::OP_RESET:   return 3'h0;
            fpc_pkg::OP_READ_ID: return 3'h2;
            fpc_pkg::OP_PROGRAM: return 3'h3;
            default:             return 3'h5;
        endcase
    endfunction

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg    <= S_WAIT;
            op_reg       <= 3'h0;
            step_reg     <= 3'h0;
            blk_reg      <= 3'h0;
            idsel_reg    <= 1'b0;
            prev_reg     <= 8'h00;
            rdata_reg    <= 8'h00;
            id_reg       <= 16'h0000;
            fail_reg     <= 1'b0;
            done_reg     <= 1'b0;
            refused_reg  <= 1'b0;
            err_seen_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_WAIT: begin
                    // after power-up or error reset, keep off the bus
                    if (tmr_idle)
                        state_reg <= S_IDLE;
                end
                S_IDLE: begin
                    if (wr_in && addr_in == fpc_pkg::REG_CMD) begin
                        op_reg      <= wdata_in[2:0];
                        done_reg    <= 1'b0;
                        refused_reg <= 1'b0;
                        step_reg    <= 3'h0;
                        blk_reg     <= 3'h0;
                        idsel_reg   <= 1'b0;
                        case (wdata_in[2:0])
                            fpc_pkg::OP_READ:       state_reg <= S_READ;
                            fpc_pkg::OP_PROGRAM:    state_reg <= S_CHECK;
                            fpc_pkg::OP_CHIP_ERASE, fpc_pkg::OP_READ_ID,
                            fpc_pkg::OP_RESET: begin
                                fail_reg  <= 1'b0;
                                state_reg <= S_SEQ;
                            end
                            fpc_pkg::OP_BLOCK_ERASE: begin
                                fail_reg <= 1'b0;
                                if (blocks_reg == 8'h00) begin
                                    refused_reg <= 1'b1;
                                    done_reg    <= 1'b1;
                                end else
                                    state_reg <= S_SEQ;
                            end
                            default: refused_reg <= 1'b1;
                        endcase
                    end
                end
                S_CHECK: begin
                    // read the old byte first
                    if (cyc_done) begin
                        if ((~cyc_rdata & wdata_reg) != 8'h00) begin
                            refused_reg <= 1'b1;
                            done_reg    <= 1'b1;
                            state_reg   <= S_IDLE;
                        end else begin
                            fail_reg  <= 1'b0;
                            state_reg <= S_SEQ;
                        end
                    end
                end
                S_SEQ: begin
                    if (cyc_done) begin
                        if (step_reg == last_step(op_reg)) begin
                            if (op_reg == fpc_pkg::OP_BLOCK_ERASE && blk_reg != 3'h7 &&
                                (blocks_reg >> (blk_reg + 3'h1)) != 8'h00) begin
                                blk_reg <= blk_reg + 3'h1;
                            end else begin
                                case (op_reg)
                                    fpc_pkg::OP_READ_ID: state_reg <= S_ID;
                                    fpc_pkg::OP_RESET: begin
                                        err_seen_reg <= 1'b0;
                                        done_reg     <= 1'b1;
                                        state_reg    <= S_WAIT;
                                    end
                                    default: state_reg <= S_POLL1;
                                endcase
                            end
                        end else
                            step_reg <= step_reg + 3'h1;
                    end else if (step_reg == 3'h5 && op_reg == fpc_pkg::OP_BLOCK_ERASE &&
                                 !blocks_reg[blk_reg]) begin
                        blk_reg <= blk_reg + 3'h1;
                    end
                end
                S_POLL1: begin
                    if (cyc_done) begin
                        prev_reg  <= cyc_rdata;
                        state_reg <= S_POLL2;
                    end
                end
                S_POLL2: begin
                    // back-to-back reads with nothing between them
                    if (cyc_done) begin
                        prev_reg <= cyc_rdata;
                        if (!toggling(prev_reg, cyc_rdata)) begin
                            done_reg  <= 1'b1;
                            state_reg <= S_IDLE;
                        end else if (prev_reg[fpc_pkg::ERROR_BIT]) begin
                            // recheck: may have finished just as error rose
                            state_reg <= S_RECOVER;
                        end
                    end
                end
                S_RECOVER: begin
                    if (cyc_done) begin
                        done_reg  <= 1'b1;
                        state_reg <= S_IDLE;
                        if (toggling(prev_reg, cyc_rdata)) begin
                            fail_reg     <= 1'b1;
                            err_seen_reg <= 1'b1;
                        end
                    end
                end
                S_READ: begin
                    if (cyc_done) begin
                        rdata_reg <= cyc_rdata;
                        done_reg  <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_ID: begin
                    if (cyc_done) begin
                        if (!idsel_reg) begin
                            id_reg[7:0] <= cyc_rdata;
                            idsel_reg   <= 1'b1;
                        end else begin
                            id_reg[15:8] <= cyc_rdata;
                            done_reg     <= 1'b1;
                            state_reg    <= S_IDLE;
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // program operands and block selection
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg   <= 17'h00000;
            wdata_reg  <= 8'h00;
            blocks_reg <= 8'h00;
        end else if (wr_in && !busy) begin
            case (addr_in)
                fpc_pkg::REG_ADDR:   addr_reg   <= wdata_in[16:0];
                fpc_pkg::REG_WDATA:  wdata_reg  <= wdata_in[7:0];
                fpc_pkg::REG_BLOCKS: blocks_reg <= wdata_in[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in)
            rdata_out <= 32'h00000000;
        else if (rd_in) begin
            case (addr_in)
                fpc_pkg::REG_ADDR:    rdata_out <= {15'h0000, addr_reg};
                fpc_pkg::REG_WDATA:   rdata_out <= {24'h000000, wdata_reg};
                fpc_pkg::REG_RDATA:   rdata_out <= {24'h000000, rdata_reg};
                fpc_pkg::REG_STATUS:  rdata_out <= {27'h0000000, state_reg != S_WAIT, refused_reg,
                                                    fail_reg, done_reg, busy};
                fpc_pkg::REG_BLOCKS:  rdata_out <= {24'h000000, blocks_reg};
                fpc_pkg::REG_IDCODES: rdata_out <= {16'h0000, id_reg};
                default:              rdata_out <= 32'h00000000;
            endcase
        end else
            rdata_out <= 32'h00000000;
    end
endmodule // fpc_host

/* File: hw/fpc_pkg.sv */
package fpc_pkg;
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned ADDR_W         = 17;
    localparam int unsigned DATA_W         = 8;
    // host register map (byte addresses)
    localparam logic [7:0] REG_CMD         = 8'h00;
    localparam logic [7:0] REG_ADDR        = 8'h04;
    localparam logic [7:0] REG_WDATA       = 8'h08;
    localparam logic [7:0] REG_RDATA       = 8'h0C;
    localparam logic [7:0] REG_STATUS      = 8'h10;
    localparam logic [7:0] REG_BLOCKS      = 8'h14;
    localparam logic [7:0] REG_IDCODES     = 8'h18;
    // command codes written to REG_CMD
    localparam logic [2:0] OP_READ         = 3'h1;
    localparam logic [2:0] OP_PROGRAM      = 3'h2;
    localparam logic [2:0] OP_CHIP_ERASE   = 3'h3;
    localparam logic [2:0] OP_BLOCK_ERASE  = 3'h4;
    localparam logic [2:0] OP_READ_ID      = 3'h5;
    localparam logic [2:0] OP_RESET        = 3'h6;
    // status word bit positions
    localparam int unsigned POLL_BIT       = 7;
    localparam int unsigned TOGGLE_BIT     = 6;
    localparam int unsigned ERROR_BIT      = 5;
    // host status register bit positions
    localparam int unsigned ST_BUSY        = 0;
    localparam int unsigned ST_DONE        = 1;
    localparam int unsigned ST_FAIL        = 2;
    localparam int unsigned ST_REFUSED     = 3;
    localparam int unsigned ST_READY       = 4;
    localparam int unsigned NUM_BLOCKS     = 8;
    localparam int unsigned BLOCK_SHIFT    = 14;
    // timing
    localparam int unsigned RESET_READY_US = 10;
    localparam int unsigned POWERUP_US     = 50;
    localparam int unsigned RESET_READY_CYC = RESET_READY_US * CLK_MHZ;
    localparam int unsigned POWERUP_CYC    = POWERUP_US * CLK_MHZ;
    localparam int unsigned BUS_PHASE_CYC  = 4;
    localparam int unsigned TIMER_W        = 16;
    // unlock / command bus cycles
    localparam logic [15:0] UNLOCK_A1      = 16'h5555;
    localparam logic [15:0] UNLOCK_A2      = 16'h2AAA;
    localparam logic [7:0]  UNLOCK_D1      = 8'hAA;
    localparam logic [7:0]  UNLOCK_D2      = 8'h55;
    localparam logic [7:0]  CODE_RESET     = 8'hF0;
    localparam logic [7:0]  CODE_PROGRAM   = 8'hA0;
    localparam logic [7:0]  CODE_ERASE     = 8'h80;
    localparam logic [7:0]  CODE_CHIP      = 8'h10;
    localparam logic [7:0]  CODE_BLOCK     = 8'h30;
    localparam logic [7:0]  CODE_ID        = 8'h90;
endpackage

/* File: hw/fpc_bus_cycle.sv */
`timescale 1ns/10ps
// one parallel bus read or write cycle on the flash pins
module fpc_bus_cycle (
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    input  wire logic                       start_in,
    input  wire logic                       write_in,
    input  wire logic [fpc_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [fpc_pkg::DATA_W-1:0] wdata_in,
    input  wire logic [fpc_pkg::DATA_W-1:0] dq_in,
    output logic                            done_out,
    output logic [fpc_pkg::DATA_W-1:0]      rdata_out,
    output logic [fpc_pkg::ADDR_W-1:0]      addr_out,
    output logic [fpc_pkg::DATA_W-1:0]      dq_out,
    output logic                            dq_oe_n_out,
    output logic                            ce_n_out,
    output logic                            oe_n_out,
    output logic                            we_n_out
);
    logic [2:0] cnt_reg;
    logic       act_reg;
    logic       wr_reg;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_reg     <= 1'b0;
            wr_reg      <= 1'b0;
            cnt_reg     <= 3'h0;
            done_out    <= 1'b0;
            rdata_out   <= 8'h00;
            addr_out    <= 17'h00000;
            dq_out      <= 8'h00;
            dq_oe_n_out <= 1'b1;
            ce_n_out    <= 1'b1;
            oe_n_out    <= 1'b1;
            we_n_out    <= 1'b1;
        end else begin
            done_out <= 1'b0;
            // skip the done cycle so the caller can move on before the next start
            if (!act_reg && start_in && !done_out) begin
                act_reg     <= 1'b1;
                wr_reg      <= write_in;
                cnt_reg     <= 3'h0;
                addr_out    <= addr_in;
                dq_out      <= wdata_in;
                dq_oe_n_out <= !write_in;
                ce_n_out    <= 1'b0;
                oe_n_out    <= write_in;
                we_n_out    <= !write_in;
            end else if (act_reg) begin
                cnt_reg <= cnt_reg + 3'h1;
                if (cnt_reg == 3'(fpc_pkg::BUS_PHASE_CYC - 1)) begin
                    // sample before strobes rise, data is held by device
                    if (!wr_reg)
                        rdata_out <= dq_in;
                    act_reg     <= 1'b0;
                    ce_n_out    <= 1'b1;
                    oe_n_out    <= 1'b1;
                    we_n_out    <= 1'b1;
                    dq_oe_n_out <= 1'b1;
                    done_out    <= 1'b1;
                end
            end
        end
    end
endmodule // fpc_bus_cycle

/* File: hw/fpc_timer.sv */
`timescale 1ns/10ps
// wait timer, load a count and report expiry as a level
module fpc_timer (
    input  wire logic                        core_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        load_in,
    input  wire logic [fpc_pkg::TIMER_W-1:0] count_in,
    output logic                             idle_out
);
    logic [fpc_pkg::TIMER_W-1:0] cnt_reg;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            // power-up wait starts straight out of reset
            cnt_reg  <= 16'(fpc_pkg::POWERUP_CYC);
            idle_out <= 1'b0;
        end else if (load_in) begin
            cnt_reg  <= count_in;
            idle_out <= 1'b0;
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg  <= cnt_reg - 16'h0001;
            idle_out <= 1'b0;
        end else begin
            idle_out <= 1'b1;
        end
    end
endmodule // fpc_timer

/* File: testbench/fpc_host_props.sv */
`timescale 1ns/10ps
module fpc_host_props (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [16:0] fl_addr_out,
    input wire logic        fl_dq_oe_n_out,
    input wire logic        fl_ce_n_out,
    input wire logic        fl_oe_n_out,
    input wire logic        fl_we_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    int unsigned up_reg;
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) up_reg <= 0;
        else if (up_reg < fpc_pkg::POWERUP_CYC) up_reg <= up_reg + 1;
    sequence s_wr; !fl_we_n_out [*4] ##1 fl_we_n_out; endsequence
    sequence s_rd; !fl_oe_n_out [*4] ##1 fl_oe_n_out; endsequence
    AST_PWR: assert property (up_reg < fpc_pkg::POWERUP_CYC - 1 |-> fl_ce_n_out) else $error("early access");
    AST_WR: assert property ($fell(fl_we_n_out) |-> s_wr) else $error("write strobe");
    AST_RD: assert property ($fell(fl_oe_n_out) |-> s_rd) else $error("read strobe");
    AST_EXCL: assert property (fl_oe_n_out || fl_we_n_out) else $error("strobe overlap");
    AST_CE: assert property (!(fl_oe_n_out && fl_we_n_out) |-> !fl_ce_n_out) else $error("no select");
    AST_DRV: assert property (!fl_oe_n_out |-> fl_dq_oe_n_out) else $error("drive on read");
    AST_ADR: assert property (!fl_ce_n_out && $past(!fl_ce_n_out) |-> $stable(fl_addr_out)) else $error("addr");
    AST_RDAT: assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("stray data");
endmodule // fpc_host_props
bind fpc_host fpc_host_props u_props (.core_clk_in(core_clk_in), .rst_in(rst_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .fl_addr_out(fl_addr_out), .fl_dq_oe_n_out(fl_dq_oe_n_out), .fl_ce_n_out(fl_ce_n_out), .fl_oe_n_out(fl_oe_n_out),
    .fl_we_n_out(fl_we_n_out));

/* File: testbench/fpc_flash_model.sv */
`timescale 1ns/10ps
module fpc_flash_model #(
    parameter logic [7:0] MFR = 8'hC3, // arbitrary
    parameter logic [7:0] DEV = 8'h6E  // arbitrary
) (
    input  wire logic [16:0] addr_in,
    input  wire logic [7:0]  dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        fail_in,
    output logic [7:0]       dq_out
);
    logic [7:0] mem [0:131071];
    logic [7:0] last = 8'h0;
    logic       pgm = 1'h0, idm = 1'h0, tog = 1'h0, err = 1'h0;
    int         busy = 0;
    wire        st = busy > 0 || err;
    wire        rd_act = !ce_n_in && !oe_n_in;
    wire        wr_act = !ce_n_in && !we_n_in;
    wire  [7:0] val = st ? {~mem[addr_in][7], tog, err, 5'h0} :
                      idm ? (addr_in[0] ? DEV : MFR) : mem[addr_in];
    // released bus must not look like valid data
    assign dq_out = (ce_n_in | oe_n_in) ? ~last : val;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // select and strobe rise together, so end of read is either one rising
    always @(negedge rd_act) begin
        last = val;
        tog = tog ^ st;
        busy = (busy > 0 && !err) ? busy - 1 : busy;
    end
    // take the write once address and data have settled, not at the release edge
    always @(posedge wr_act) begin
        #1;
        if (pgm) begin
            mem[addr_in] = mem[addr_in] & dq_in;
            busy = 3;
            err = fail_in;
            pgm = 1'h0;
        end else case (dq_in)
            8'hA0: pgm = 1'h1;
            8'h90: idm = 1'h1;
            8'h10: begin
                foreach (mem[i]) mem[i] = 8'hFF;
                busy = 3;
            end
            8'h30: for (int i = 0; i < 16384; i++) mem[{addr_in[16:14], 14'h0} + i] = 8'hFF;
            8'hF0: {idm, err, busy} = 0;
            default: ;
        endcase
    end
endmodule // fpc_flash_model

/* File: testbench/fpc_host_bench.sv */
`timescale 1ns/10ps
module fpc_host_bench;
    logic        clk, rst, wr, rd, fail, oe_dq_n, ce_n, oe_n, we_n;
    logic [7:0]  addr, dq_o, dq_f;
    logic [16:0] fa;
    logic [31:0] wd, rdata, d;
    int          err_count, cmp_count;
    wire  [7:0]  dq = oe_dq_n ? dq_f : dq_o;
    fpc_host u_dut (.core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .fl_addr_out(fa), .fl_dq_in(dq), .fl_dq_out(dq_o), .fl_dq_oe_n_out(oe_dq_n),
        .fl_ce_n_out(ce_n), .fl_oe_n_out(oe_n), .fl_we_n_out(we_n));
    fpc_flash_model u_fm (.addr_in(fa), .dq_in(dq), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .fail_in(fail), .dq_out(dq_f));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr, rd, addr, wd} <= {w, !w, a, v};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [31:0] e);
        cmp_count++;
        if (d !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, d, e);
        end
    endtask
    task automatic op(input logic [2:0] c, input logic [16:0] a, input logic [7:0] v, input logic [31:0] e);
        bus(1'h1, fpc_pkg::REG_ADDR, {15'h0, a});
        bus(1'h1, fpc_pkg::REG_WDATA, {24'h0, v});
        bus(1'h1, fpc_pkg::REG_CMD, {29'h0, c});
        for (int i = 0; i < 3000; i++) begin
            bus(1'h0, fpc_pkg::REG_STATUS, 32'h0);
            if (d[fpc_pkg::ST_BUSY] === 1'h0) break;
        end
        chk(e);
    endtask
    task automatic peek(input logic [16:0] a, input logic [7:0] e);
        op(fpc_pkg::OP_READ, a, 8'h0, 32'h12);
        bus(1'h0, fpc_pkg::REG_RDATA, 32'h0);
        chk({24'h0, e});
    endtask
    task automatic t_id();
        bus(1'h0, fpc_pkg::REG_STATUS, 32'h0);
        chk(32'h1);
        repeat (fpc_pkg::POWERUP_CYC) @(posedge clk);
        op(fpc_pkg::OP_READ_ID, 17'h0, 8'h0, 32'h12);
        bus(1'h0, fpc_pkg::REG_IDCODES, 32'h0);
        chk({16'h0, u_fm.DEV, u_fm.MFR});
        op(fpc_pkg::OP_RESET, 17'h0, 8'h0, 32'h12);
        peek(17'h2, 8'hFF);
        $display("id test done");
    endtask
    task automatic t_prog();
        op(fpc_pkg::OP_PROGRAM, 17'h4001, 8'h5A, 32'h12);
        peek(17'h4001, 8'h5A);
        op(fpc_pkg::OP_PROGRAM, 17'h4001, 8'hA5, 32'h1A);
        op(fpc_pkg::OP_PROGRAM, 17'h10, 8'h00, 32'h12);
        fail <= 1'h1;
        op(fpc_pkg::OP_PROGRAM, 17'h20, 8'h0F, 32'h16);
        fail <= 1'h0;
        op(fpc_pkg::OP_RESET, 17'h0, 8'h0, 32'h12);
        peek(17'h10, 8'h00);
        $display("program test done");
    endtask
    task automatic t_erase();
        bus(1'h1, fpc_pkg::REG_BLOCKS, 32'h2);
        op(fpc_pkg::OP_BLOCK_ERASE, 17'h0, 8'h0, 32'h12);
        peek(17'h4001, 8'hFF);
        peek(17'h10, 8'h00);
        op(fpc_pkg::OP_CHIP_ERASE, 17'h0, 8'h0, 32'h12);
        peek(17'h10, 8'hFF);
        bus(1'h0, 8'h1C, 32'h0);
        chk(32'h0);
        bus(1'h1, fpc_pkg::REG_CMD, 32'h7);
        bus(1'h0, fpc_pkg::REG_STATUS, 32'h0);
        chk(32'h18);
        $display("erase test done");
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, wr, rd, fail, addr, wd} = {4'h8, 40'h0};
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_id();
        t_prog();
        t_erase();
        test_done();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule // fpc_host_bench
